// file: rtl/async_serial_transmitter.sv
// Asynchronous transmit half of the enhanced serial port, APB slave.
// Assumes one 50 MHz clock; receive pin comes from outside the clock domain.
//
// What this block does
// - Transmit line idles at mark level whenever port enabled and no frame is sent.
// - Frame is start bit low, eight or nine data bits, stop high.
// - Every bit, start and stop included, lasts exactly one bit period.
// - Data goes out least significant bit first, shared format and rate.
// - No hardware parity; software puts any parity in ninth bit.
// - Baud generator divides clock, 8 or 16 bit, from divisor registers.
// - Transmitter runs only with enable set, clocked off, port enabled.
// - Port enable makes transmit pin an output of the serial logic.
// - Port enable forces receive pin input, still readable, latch blocked.
// - Buffer-empty flag sets as soon as transmitter enable sets.
// - Buffer write loads shifter at once when shifter is empty.
// - Busy shifter: character waits, moves within one cycle after stop.
// - Start, data and stop follow each load at once, back to back.
// - Buffer-empty flag set unless shifter busy and character queued.
// - Buffer-empty flag not cleared at write; valid two cycles later.
// - Buffer-empty flag read-only; follows state while enable set, held clear while enable clear.
// - Interrupt output is flag gated by transmit interrupt enable.
// - Shifter-empty bit set when empty, clear from load to last bit.
// - Nine-bit mode shifts ninth bit last, loaded with buffer write.
// - Clearing port enable resets the whole transmit path.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
module async_serial_transmitter
    import serial_tx_pkg::*;
#(
    parameter int divisor_width = 16
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             tx_out,
    output logic             tx_oe,
    output logic             rx_out,
    output logic             rx_oe,
    input  wire logic        rx_in,
    output logic             tx_irq
);

    // Elaboration check: the divisor registers are fixed at two bytes
    if (divisor_width != 16)
        $error("divisor_width must be 16");

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]  tcs;
    logic        port_en;
    logic        wide;
    logic [15:0] divisor;
    logic [3:0]  pin_dir;
    logic        irq_en;
    logic [8:0]  buf_data;
    logic        buf_full;
    logic [9:0]  shifter;
    logic [3:0]  bits_left;
    logic [15:0] baud_cnt;
    logic [1:0]  flag_delay;
    logic        empty_flag;
    logic [2:0]  rx_sync;
    logic        rx_seen;
    tx_state_e   state;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire access     = psel && penable;
    wire wr         = access && pwrite;
    wire wr_tcs     = wr && paddr == addr_transmit_control_status;
    wire wr_rcs     = wr && paddr == addr_receive_control_status;
    wire wr_bct     = wr && paddr == addr_baud_control;
    wire wr_dlo     = wr && paddr == addr_baud_divisor_low;
    wire wr_dhi     = wr && paddr == addr_baud_divisor_high;
    wire wr_buf     = wr && paddr == addr_transmit_buffer;
    wire wr_dir     = wr && paddr == addr_port_direction;
    wire wr_ien     = wr && paddr == addr_irq_enable;
    wire mapped     = paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0;
    wire tx_enabled = tcs[tcs_tx_enable];
    wire run        = tx_enabled && !tcs[tcs_clocked] && port_en;
    wire nine       = tcs[tcs_nine_bit];
    // Baud tick: 8-bit mode ignores the high divisor byte
    wire [15:0] div_eff  = wide ? divisor : {8'h00, divisor[7:0]};
    wire        baud_tick = baud_cnt == 16'h0000;
    wire        last_bit  = state == tx_shift && bits_left == 4'h1
                            && baud_tick;
    wire        shifter_free = state == tx_idle || last_bit;
    wire        load     = run && (buf_full || wr_buf) && shifter_free;
    wire [8:0]  load_src = buf_full ? buf_data
                                    : {tcs[tcs_ninth_bit], pwdata[7:0]};
    // Stop(1) in eight-bit mode (shifted in as fill for nine), data, start(0); shift right so the LSB leaves first
    wire [9:0]  frame    = nine ? {load_src, 1'b0}
                                : {1'b1, load_src[7:0], 1'b0};
    wire [3:0]  frame_len = nine ? 4'(frame_bits_max) : 4'(frame_bits_max - 1);
    wire        queued   = run && buf_full && !shifter_free;
    wire        next_flag = tx_enabled && !(buf_full || queued);

    function automatic logic [7:0] rd_mux(input logic [7:0] a);
        unique case (a)
            addr_transmit_control_status:
                rd_mux = {tcs[7:2], state == tx_idle, tcs[0]};
            addr_receive_control_status: rd_mux = {port_en, 7'h00};
            addr_baud_control:      rd_mux = {4'h0, wide, 3'h0};
            addr_baud_divisor_low:  rd_mux = divisor[7:0];
            addr_baud_divisor_high: rd_mux = divisor[15:8];
            addr_port_direction:    rd_mux = {3'h0, rx_seen, pin_dir};
            addr_irq_enable:        rd_mux = {6'h00, empty_flag, irq_en};
            default:                rd_mux = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // APB slave, zero wait states
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tcs     <= reset_transmit_control;
            port_en <= 1'b0;
            wide    <= 1'b0;
            divisor <= 16'h0000;
            pin_dir <= 4'(reset_port_direction);
            irq_en  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite)
                       ? {24'h000000, rd_mux(paddr)} : 32'h0000_0000;
            // Shifter-empty bit is read-only
            if (wr_tcs)
                tcs <= {pwdata[7:2], 1'b0, pwdata[0]};
            if (wr_rcs)
                port_en <= pwdata[rcs_port_en];
            if (wr_bct)
                wide <= pwdata[bct_wide];
            if (wr_dlo)
                divisor[7:0] <= pwdata[7:0];
            if (wr_dhi)
                divisor[15:8] <= pwdata[7:0];
            if (wr_dir)
                pin_dir <= pwdata[3:0];
            if (wr_ien)
                irq_en <= pwdata[ien_tx_empty];
        end
    end

    // ------------------------------------------------------------------
    // Transmit buffer and shifter
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            buf_full  <= 1'b0;
            buf_data  <= 9'h000;
            shifter   <= 10'h3ff;
            bits_left <= 4'h0;
            baud_cnt  <= 16'h0000;
            state     <= tx_idle;
        end
        else if (!run)
        begin
            // Disabling or clearing port enable flushes everything
            buf_full  <= 1'b0;
            shifter   <= 10'h3ff;
            bits_left <= 4'h0;
            baud_cnt  <= 16'h0000;
            state     <= tx_idle;
        end
        else
        begin
            if (wr_buf && !shifter_free)
            begin
                buf_full <= 1'b1;
                buf_data <= {tcs[tcs_ninth_bit], pwdata[7:0]};
            end
            else if (load && buf_full)
                buf_full <= 1'b0;
            if (load)
            begin
                shifter   <= frame;
                bits_left <= frame_len;
                baud_cnt  <= div_eff;
                state     <= tx_shift;
            end
            else if (state == tx_shift)
            begin
                baud_cnt <= baud_tick ? div_eff : baud_cnt - 16'h0001;
                if (baud_tick)
                begin
                    shifter   <= {1'b1, shifter[9:1]};
                    bits_left <= bits_left - 4'h1;
                    if (bits_left == 4'h1)
                        state <= tx_idle;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Flags, pins, receive pin sampling
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_delay <= 2'h0;
            empty_flag <= 1'b0;
            tx_irq     <= 1'b0;
            tx_out     <= 1'b1;
            tx_oe      <= 1'b0;
            rx_out     <= 1'b0;
            rx_oe      <= 1'b0;
            rx_sync    <= 3'h0;
            rx_seen    <= 1'b0;
        end
        else
        begin
            // Flag sets at once on enable; a write shows two cycles later
            flag_delay <= {flag_delay[0], wr_buf};
            if (!tx_enabled)
                empty_flag <= 1'b0;
            else if (!empty_flag || !(wr_buf || flag_delay[0]))
                empty_flag <= next_flag;
            tx_irq <= empty_flag && irq_en;
            // Idle mark also covers a stopped or disabled shifter
            tx_out <= port_en ? (state == tx_shift ? shifter[0] : 1'b1)
                              : pin_dir[pd_tx_latch];
            tx_oe  <= port_en || !pin_dir[pd_tx_dir];
            rx_out <= pin_dir[pd_rx_latch];
            rx_oe  <= !port_en && !pin_dir[pd_rx_dir];
            rx_sync <= {rx_sync[1:0], rx_in};
            if (rx_sync[2] == rx_sync[1])
                rx_seen <= rx_sync[1];
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence load_seq;
        load;
    endsequence

    sequence start_seq;
        tx_out == 1'b0;
    endsequence

    idle_mark_a: assert property (@(posedge pclk) disable iff (!presetn)
        port_en && $past(port_en) && $past(state) == tx_idle |-> tx_out)
        else $error("line not at mark while idle");
    start_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        load_seq ##1 port_en |=> start_seq)
        else $error("no start bit after load");
    empty_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
        load |=> state != tx_idle)
        else $error("shifter-empty bit not cleared on load");
    bit_time_a: assert property (@(posedge pclk) disable iff (!presetn)
        run && state == tx_shift && baud_tick && !last_bit
        |=> baud_cnt == $past(div_eff))
        else $error("bit period counter not reloaded");
    gate_run_a: assert property (@(posedge pclk) disable iff (!presetn)
        !run |=> state == tx_idle && !buf_full)
        else $error("transmitter active while not enabled");
    flag_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(tx_enabled) && !buf_full |=> empty_flag)
        else $error("flag not set on enable");
    flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        empty_flag && wr_buf |=> empty_flag)
        else $error("flag cleared at buffer write");
    irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !irq_en ##1 !irq_en |-> !tx_irq)
        else $error("interrupt without enable");
    pin_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        port_en |=> tx_oe && !rx_oe)
        else $error("pin direction not taken over");
    queue_a: assert property (@(posedge pclk) disable iff (!presetn)
        buf_full && last_bit && run |=> state == tx_shift && !buf_full)
        else $error("queued character not transferred");

endmodule

// file: rtl/serial_tx_pkg.sv
// Package for the asynchronous serial transmitter: register map, bit fields,
// reset values and timing figures.
// Assumes a 50 MHz APB clock and 32-bit APB data with one register a word.
package serial_tx_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] addr_transmit_control_status = 8'h00;
    localparam logic [7:0] addr_receive_control_status  = 8'h04;
    localparam logic [7:0] addr_baud_control            = 8'h08;
    localparam logic [7:0] addr_baud_divisor_low        = 8'h0c;
    localparam logic [7:0] addr_baud_divisor_high       = 8'h10;
    localparam logic [7:0] addr_transmit_buffer         = 8'h14;
    localparam logic [7:0] addr_port_direction          = 8'h18;
    localparam logic [7:0] addr_irq_enable              = 8'h1c;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int tcs_nine_bit   = 6;
    localparam int tcs_tx_enable  = 5;
    localparam int tcs_clocked    = 4;
    localparam int tcs_high_speed = 2;
    localparam int tcs_shift_mt   = 1;
    localparam int tcs_ninth_bit  = 0;
    localparam int rcs_port_en    = 7;
    localparam int bct_wide       = 3;
    localparam int pd_tx_dir      = 0;
    localparam int pd_rx_dir      = 1;
    localparam int pd_tx_latch    = 2;
    localparam int pd_rx_latch    = 3;
    localparam int ien_tx_empty   = 0;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [7:0] reset_transmit_control = 8'h02;
    localparam logic [7:0] reset_byte_zero        = 8'h00;
    localparam logic [7:0] reset_port_direction   = 8'h03;
    localparam int clk_hz         = 50_000_000;
    localparam int tcy_ns         = 200;
    localparam int clk_ns         = 1_000_000_000 / clk_hz;
    localparam int tcy_cycles     = (tcy_ns + clk_ns - 1) / clk_ns;
    localparam int frame_bits_max = 11;

    typedef enum logic [1:0] {tx_idle, tx_shift} tx_state_e;

endpackage

// file: sim/async_serial_transmitter_tb_top.sv
// Testbench for the asynchronous serial transmitter over APB.
// Assumes a pull-up on the transmit pin and the receiver model beside.
module async_serial_transmitter_tb_top;
    import serial_tx_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0;
    logic        pwrite = 0, rx_in = 1, nine = 0, slv;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, q, prdata;
    logic        pready, pslverr, tx_out, tx_oe, rx_out, rx_oe, tx_irq;
    logic [16:0] bitc = 17'd4;
    logic [8:0]  rx_char;
    logic        rx_ferr;
    int          rx_count, rx_gap, errors = 0, cmp_count = 0;
    // Undriven pin rests at mark through the pull-up
    wire         line = tx_oe ? tx_out : 1'b1;

    always #10 pclk = ~pclk;

    async_serial_transmitter dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_out(tx_out), .tx_oe(tx_oe),
        .rx_out(rx_out), .rx_oe(rx_oe), .rx_in(rx_in), .tx_irq(tx_irq));
    serial_rx_model far (.pclk(pclk), .line(line), .nine(nine),
        .bitc(bitc), .rx_char(rx_char), .rx_ferr(rx_ferr),
        .rx_count(rx_count), .rx_gap(rx_gap));

    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            errors++;
        q = prdata;
        slv = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    function int bit_len(input logic wide, input logic [7:0] hi, lo);
        return (wide ? {hi, lo} : {8'h00, lo}) + 1;
    endfunction

    function int frame_len(input logic n9, input int bl);
        return bl * (n9 ? 11 : 10);
    endfunction

    task wait_char(input int prev);
        int n;
        n = 0;
        while (rx_count == prev && n < 3000)
        begin
            @(posedge pclk);
            n++;
        end
    endtask

    task send(input logic [8:0] c);
        // Ninth bit goes in before the low byte
        apb(1, addr_transmit_control_status, {25'h0, nine, 5'h10, c[8]});
        apb(1, addr_transmit_buffer, {24'h0, c[7:0]});
    endtask

    task print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        #1_000_000;
        errors++;
        print_verdict;
    end

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial
    begin
        int pc;
        logic [8:0] c;
        void'($urandom(46));
        repeat (8) @(posedge pclk);
        presetn <= 1;
        apb(0, addr_transmit_control_status, 0);
        check(q, {24'h0, reset_transmit_control});
        apb(0, 8'h20, 0);
        check(32'(slv), 1);
        check(32'({line, tx_oe}), 32'h2);
        apb(1, addr_receive_control_status, 32'h80);
        rx_in <= 1'($urandom);
        repeat (4) @(posedge pclk);
        check(32'({tx_oe, rx_oe}), 32'h2);
        apb(0, addr_port_direction, 0);
        check(32'(q[4]), 32'(rx_in));
        apb(1, addr_baud_divisor_high, 1);
        apb(1, addr_baud_divisor_low, 3);
        bitc = 17'(bit_len(0, 8'h01, 8'h03));
        for (int k = 0; k < 3; k++)
        begin
            apb(1, addr_receive_control_status, k == 2 ? 0 : 32'h80);
            apb(1, addr_transmit_control_status, k == 1 ? 32'h30 : 32'h20);
            pc = rx_count;
            apb(1, addr_transmit_buffer, 32'h55);
            repeat (60) @(posedge pclk);
            check(32'({rx_count - pc, line}), k == 0 ? 32'h3 : 32'h1);
        end
        apb(1, addr_receive_control_status, 32'h80);
        apb(1, addr_transmit_control_status, 32'h20);
        apb(0, addr_irq_enable, 0);
        check({q[30:0], tx_irq}, 32'h4);
        // Interrupt once enabled while the buffer is empty, nothing left to send
        apb(1, addr_irq_enable, 32'h1);
        apb(0, addr_irq_enable, 0);
        check({q[30:0], tx_irq}, 32'h7);
        for (int k = 0; k < 8; k++)
        begin
            nine = k[2];
            c = 9'($urandom);
            c[8] = nine & (k == 4 || c[8]);
            pc = rx_count;
            send(c);
            apb(0, addr_transmit_control_status, 0);
            check(32'(q[1]), 0);
            wait_char(pc);
            check({22'h0, rx_ferr, rx_char}, {23'h0, c});
            repeat (bitc) @(posedge pclk);
            apb(0, addr_transmit_control_status, 0);
            check(32'({q[1], line}), 32'h3);
        end
        apb(1, addr_baud_divisor_high, 0);
        apb(1, addr_baud_divisor_low, 5);
        apb(1, addr_baud_control, 32'h8);
        bitc = 17'(bit_len(1, 8'h00, 8'h05));
        nine = 0;
        pc = rx_count;
        send(9'h0a5);
        apb(1, addr_transmit_buffer, 32'h3c);
        repeat (2) @(posedge pclk);
        check(32'(tx_irq), 1);
        apb(1, addr_irq_enable, 0);
        apb(0, addr_irq_enable, 0);
        check(q, 0);
        wait_char(pc);
        check(32'(rx_char), 32'h0a5);
        repeat (bitc) @(posedge pclk);
        apb(0, addr_irq_enable, 0);
        check(q, 32'h2);
        wait_char(pc + 1);
        check(32'(rx_char), 32'h03c);
        check(rx_gap, frame_len(0, bitc));
        pc = rx_count;
        apb(1, addr_transmit_buffer, 32'h0f);
        apb(1, addr_transmit_buffer, 32'hf0);
        repeat (20) @(posedge pclk);
        apb(1, addr_receive_control_status, 0);
        repeat (2) @(posedge pclk);
        check(32'(tx_oe), 0);
        apb(1, addr_receive_control_status, 32'h80);
        apb(0, addr_transmit_control_status, 0);
        check(32'(q[1]), 1);
        repeat (30 * bitc) @(posedge pclk);
        check(32'({rx_count - pc < 2, line}), 32'h3);
        print_verdict;
    end
endmodule

// file: sim/serial_rx_model.sv
// Receiver model at the far end of the transmit pin.
// Assumes the line idles at mark and bitc gives clocks per bit.
module serial_rx_model (
    input  wire logic        pclk,
    input  wire logic        line,
    input  wire logic        nine,
    input  wire logic [16:0] bitc,
    output logic      [8:0]  rx_char,
    output logic             rx_ferr,
    output int               rx_count,
    output int               rx_gap
);
    timeunit 1ns;
    timeprecision 1ns;
    int cyc = 0;
    int last_start = 0;

    always @(posedge pclk)
        cyc <= cyc + 1;

    // ----------------------------------------------------------
    // Frame sampling, mid bit
    // ----------------------------------------------------------
    initial
    begin
        int nb;
        rx_count = 0;
        rx_gap = 0;
        rx_ferr = 0;
        rx_char = '0;
        forever
        begin
            @(posedge pclk iff line === 1'b0);
            // Start to start spacing shows any idle gap
            rx_gap = cyc - last_start;
            last_start = cyc;
            nb = nine ? 9 : 8;
            repeat (bitc / 2) @(posedge pclk);
            rx_ferr = (line !== 1'b0);
            rx_char = '0;
            for (int i = 0; i < nb; i++)
            begin
                repeat (bitc) @(posedge pclk);
                rx_char[i] = line;
            end
            repeat (bitc) @(posedge pclk);
            if (line !== 1'b1)
                rx_ferr = 1'b1;
            rx_count++;
        end
    end
endmodule
